// File: acd_config_decode.v
`timescale 1ns/100ps
`default_nettype none
`include "acd_defines.vh"

module acd_config_decode #(
  parameter FOUR_CH = 0,
  parameter [6:0] DEV_ADDR = 7'h2a // arbitrary value
) (
  input wire i_core_clk,
  input wire i_rstn,
  input wire i_scl,
  input wire i_sda,
  input wire i_scan_start,
  input wire i_scan_next,
  output wire o_sda_out,
  output wire o_sda_oe,
  output reg [1:0] o_scan_mode,
  output reg [3:0] o_channel_code,
  output reg o_single_ended_select,
  output reg o_reference_pin_select_mid,
  output reg [3:0] o_mux_pos,
  output reg [3:0] o_mux_neg,
  output reg o_neg_is_gnd,
  output reg o_invert,
  output reg o_sel_valid,
  output reg o_scan_busy,
  output reg o_scan_last
);

  localparam [3:0] TOP_CH = FOUR_CH ? `ACD_TOP_4CH : `ACD_TOP_12CH;
  localparam [3:0] MID_CH = FOUR_CH ? `ACD_MID_4CH : `ACD_MID_12CH;

  wire byte_valid;
  wire [7:0] rx_byte;
  reg [1:0] scan_r;
  reg [3:0] code_r;
  reg se_r;
  reg [4:0] setup_r;
  reg [3:0] cur_r;
  reg [2:0] rep_r;
  reg busy_r;
  wire ref_mode;
  reg [3:0] code_nxt;
  reg [3:0] limit_nxt;
  reg [3:0] first_nxt;
  reg last_nxt;
  reg [3:0] pos_nxt;
  reg [3:0] neg_nxt;
  reg gnd_nxt;
  reg inv_nxt;
  reg valid_nxt;
  reg [3:0] sel_ch;

  //////////////////////////////////////////////////////////////////////////
  // two-wire receiver, acknowledges a matching write address and every data byte after it
  acd_byte_rx #(
    .DEV_ADDR(DEV_ADDR)
  ) u_rx (
    .i_core_clk(i_core_clk),
    .i_rstn(i_rstn),
    .i_scl(i_scl),
    .i_sda(i_sda),
    .o_sda_out(o_sda_out),
    .o_sda_oe(o_sda_oe),
    .o_byte_valid(byte_valid),
    .o_byte(rx_byte)
  );

  assign ref_mode = setup_r[`ACD_REF_MID_BIT - `ACD_SETUP_LO];

  //////////////////////////////////////////////////////////////////////////
  // byte kind steers the byte to configuration or setup storage
  always @* begin
    code_nxt = rx_byte[`ACD_CODE_HI:`ACD_CODE_LO];
    if (FOUR_CH != 0) begin
      code_nxt[3:2] = 2'h0;
    end
  end

  always @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      scan_r <= `ACD_SCAN_RST;
      code_r <= `ACD_CODE_RST;
      se_r <= `ACD_SE_RST;
      setup_r <= `ACD_SETUP_RST;
    end else if (byte_valid) begin
      if (!rx_byte[`ACD_KIND_BIT]) begin
        scan_r <= rx_byte[`ACD_SCAN_HI:`ACD_SCAN_LO];
        code_r <= code_nxt;
        se_r <= rx_byte[`ACD_SE_BIT];
      end else if (!rx_byte[`ACD_RST_BIT]) begin
        // reset request leaves the setup contents alone
        scan_r <= `ACD_SCAN_RST;
        code_r <= `ACD_CODE_RST;
        se_r <= `ACD_SE_RST;
      end else begin
        setup_r <= rx_byte[`ACD_SETUP_HI:`ACD_SETUP_LO];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // scan span from mode and code; differential spans stay pair aligned
  always @* begin
    limit_nxt = (code_r > TOP_CH) ? TOP_CH : code_r;
    if (se_r && ref_mode && limit_nxt == TOP_CH) begin
      limit_nxt = TOP_CH - 4'h1;
    end
    case (scan_r)
      `ACD_SCAN_UP: first_nxt = 4'h0;
      `ACD_SCAN_MID: first_nxt = MID_CH;
      default: first_nxt = limit_nxt;
    endcase
    if (first_nxt > limit_nxt) begin
      first_nxt = limit_nxt; // mid start above code scans one input only
    end
    if (!se_r) begin
      limit_nxt = {limit_nxt[3:1], 1'b0};
      first_nxt = {first_nxt[3:1], 1'b0};
    end
  end

  // last step of a scan: limit reached or repeat count used up
  always @* begin
    if (scan_r == `ACD_SCAN_REP8) begin
      last_nxt = (rep_r == `ACD_REPEAT_LAST);
    end else if (scan_r == `ACD_SCAN_ONE) begin
      last_nxt = 1'b1;
    end else begin
      last_nxt = (cur_r >= limit_nxt);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // scan stepper; outside a scan the selected code drives the mux
  always @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      busy_r <= 1'b0;
      cur_r <= 4'h0;
      rep_r <= 3'h0;
    end else if (i_scan_start) begin
      busy_r <= 1'b1;
      cur_r <= first_nxt;
      rep_r <= 3'h0;
    end else if (busy_r && i_scan_next) begin
      if (last_nxt) begin
        busy_r <= 1'b0;
      end else if (scan_r == `ACD_SCAN_REP8) begin
        rep_r <= rep_r + 3'h1;
      end else if (se_r) begin
        cur_r <= cur_r + 4'h1;
      end else begin
        cur_r <= cur_r + 4'h2;
      end
    end else if (!busy_r) begin
      cur_r <= code_r;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // channel to mux decode
  always @* begin
    sel_ch = busy_r ? cur_r : code_r;
    pos_nxt = sel_ch;
    neg_nxt = 4'h0;
    gnd_nxt = 1'b1;
    inv_nxt = 1'b0;
    valid_nxt = (sel_ch <= TOP_CH);
    if (se_r) begin
      if (ref_mode && sel_ch == TOP_CH) begin
        valid_nxt = 1'b0;
      end
    end else if (ref_mode && sel_ch[3:1] == TOP_CH[3:1]) begin
      // lower input of the top pair against ground, odd code negated
      pos_nxt = {sel_ch[3:1], 1'b0};
      inv_nxt = sel_ch[0];
    end else begin
      gnd_nxt = 1'b0;
      pos_nxt = sel_ch;
      neg_nxt = {sel_ch[3:1], ~sel_ch[0]};
    end
  end

  always @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_scan_mode <= `ACD_SCAN_RST;
      o_channel_code <= `ACD_CODE_RST;
      o_single_ended_select <= `ACD_SE_RST;
      o_reference_pin_select_mid <= 1'b0;
      o_mux_pos <= 4'h0;
      o_mux_neg <= 4'h0;
      o_neg_is_gnd <= 1'b1;
      o_invert <= 1'b0;
      o_sel_valid <= 1'b1;
      o_scan_busy <= 1'b0;
      o_scan_last <= 1'b0;
    end else begin
      o_scan_mode <= scan_r;
      o_channel_code <= code_r;
      o_single_ended_select <= se_r;
      o_reference_pin_select_mid <= ref_mode;
      o_mux_pos <= pos_nxt;
      o_mux_neg <= neg_nxt;
      o_neg_is_gnd <= gnd_nxt;
      o_invert <= inv_nxt;
      o_sel_valid <= valid_nxt;
      o_scan_busy <= busy_r;
      o_scan_last <= busy_r & last_nxt;
    end
  end

endmodule

`default_nettype wire

// File: acd_defines.vh
`ifndef ACD_DEFINES_VH
`define ACD_DEFINES_VH

// written byte: kind flag and configuration fields
`define ACD_KIND_BIT 7
`define ACD_SCAN_HI 6
`define ACD_SCAN_LO 5
`define ACD_CODE_HI 4
`define ACD_CODE_LO 1
`define ACD_SE_BIT 0

// setup byte fields that this block uses
`define ACD_SETUP_HI 6
`define ACD_SETUP_LO 2
`define ACD_REF_MID_BIT 5
`define ACD_RST_BIT 1

// configuration power-up values
`define ACD_SCAN_RST 2'h0
`define ACD_CODE_RST 4'h0
`define ACD_SE_RST 1'h1
`define ACD_SETUP_RST 5'h00

// scan-mode encodings
`define ACD_SCAN_UP 2'h0
`define ACD_SCAN_REP8 2'h1
`define ACD_SCAN_MID 2'h2
`define ACD_SCAN_ONE 2'h3

// channel limits
`define ACD_TOP_12CH 4'hb
`define ACD_TOP_4CH 4'h3
`define ACD_MID_12CH 4'h6
`define ACD_MID_4CH 4'h2
`define ACD_REPEAT_LAST 3'h7

`endif

// File: acd_byte_rx.v
`timescale 1ns/100ps
`default_nettype none

// two-wire write receiver: address match, byte shift-in, acknowledge
module acd_byte_rx #(
  parameter [6:0] DEV_ADDR = 7'h2a // arbitrary value
) (
  input wire i_core_clk,
  input wire i_rstn,
  input wire i_scl,
  input wire i_sda,
  output reg o_sda_out,
  output reg o_sda_oe,
  output reg o_byte_valid,
  output reg [7:0] o_byte
);

  localparam [1:0] RX_IDLE = 2'h0;
  localparam [1:0] RX_ADDR = 2'h1;
  localparam [1:0] RX_DATA = 2'h2;
  localparam [1:0] RX_ACK = 2'h3;

  reg [2:0] scl_s_r;
  reg [2:0] sda_s_r;
  reg scl_r;
  reg sda_r;
  reg [1:0] state_r;
  reg [2:0] bit_cnt_r;
  reg [7:0] shift_r;
  reg full_r;
  reg ack_addr_r;
  wire scl_nxt;
  wire sda_nxt;
  wire scl_rise;
  wire scl_fall;
  wire start_seen;
  wire stop_seen;

  //////////////////////////////////////////////////////////////////////////
  // three-stage synchronisers; a level counts once stages 2 and 3 agree
  assign scl_nxt = (scl_s_r[1] == scl_s_r[2]) ? scl_s_r[2] : scl_r;
  assign sda_nxt = (sda_s_r[1] == sda_s_r[2]) ? sda_s_r[2] : sda_r;
  assign scl_rise = scl_nxt & ~scl_r;
  assign scl_fall = ~scl_nxt & scl_r;
  // start and stop are sda edges while scl stays high
  assign start_seen = scl_r & scl_nxt & sda_r & ~sda_nxt;
  assign stop_seen = scl_r & scl_nxt & ~sda_r & sda_nxt;

  always @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      scl_s_r <= 3'h7;
      sda_s_r <= 3'h7;
      scl_r <= 1'b1;
      sda_r <= 1'b1;
    end else begin
      scl_s_r <= {scl_s_r[1:0], i_scl};
      sda_s_r <= {sda_s_r[1:0], i_sda};
      scl_r <= scl_nxt;
      sda_r <= sda_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // byte engine; a byte is handed on only after its acknowledge clock ends
  always @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_r <= RX_IDLE;
      bit_cnt_r <= 3'h0;
      shift_r <= 8'h00;
      full_r <= 1'b0;
      ack_addr_r <= 1'b0;
      o_sda_out <= 1'b1;
      o_sda_oe <= 1'b0;
      o_byte_valid <= 1'b0;
      o_byte <= 8'h00;
    end else begin
      o_byte_valid <= 1'b0;
      o_sda_out <= 1'b0; // only ever pulls low
      if (start_seen) begin
        state_r <= RX_ADDR;
        bit_cnt_r <= 3'h0;
        full_r <= 1'b0;
        o_sda_oe <= 1'b0;
      end else if (stop_seen) begin
        state_r <= RX_IDLE;
        full_r <= 1'b0;
        o_sda_oe <= 1'b0;
      end else begin
        case (state_r)
          RX_ADDR, RX_DATA: begin
            if (scl_rise && !full_r) begin
              // take the synced level of this cycle: after an acknowledge
              // the line is released late and sda_r still shows it low
              shift_r <= {shift_r[6:0], sda_nxt};
              bit_cnt_r <= bit_cnt_r + 3'h1;
              full_r <= (bit_cnt_r == 3'h7);
            end else if (scl_fall && full_r) begin
              full_r <= 1'b0;
              ack_addr_r <= (state_r == RX_ADDR);
              // reads are not served here, so a read address is not acked
              if (state_r == RX_DATA ||
                  shift_r == {DEV_ADDR, 1'b0}) begin
                o_sda_oe <= 1'b1;
                state_r <= RX_ACK;
              end else begin
                state_r <= RX_IDLE;
              end
            end
          end
          RX_ACK: begin
            if (scl_fall) begin
              o_sda_oe <= 1'b0;
              state_r <= RX_DATA;
              bit_cnt_r <= 3'h0;
              if (!ack_addr_r) begin
                o_byte_valid <= 1'b1;
                o_byte <= shift_r;
              end
            end
          end
          default: begin
            state_r <= RX_IDLE;
          end
        endcase
      end
    end
  end

endmodule

`default_nettype wire

// File: acd_bus_master.sv
`timescale 1ns/100ps
`default_nettype none
module acd_bus_master (
  output logic o_scl,
  output logic o_sda,
  input wire logic i_sda
);
  // quarter bus period; 400 ns per bus clock
  localparam time QTR = 100;
  // both lines idle released high, bus clock still between frames
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end
  task automatic start();
    #QTR o_sda = 1'b0;
    #QTR o_scl = 1'b0;
  endtask
  task automatic stop();
    #QTR o_sda = 1'b0;
    #QTR o_scl = 1'b1;
    #QTR o_sda = 1'b1;
    #QTR;
  endtask
  // data moves only while the clock is low, sampled mid-high
  task automatic bit_clk(input logic b, output logic got);
    #QTR o_sda = b;
    #QTR o_scl = 1'b1;
    #QTR got = i_sda;
    #QTR o_scl = 1'b0;
  endtask
  // msb first, ninth clock released so the device can pull low
  task automatic write_byte(input logic [7:0] b, output logic ack);
    logic g;
    for (int i = 7; i >= 0; i--) bit_clk(b[i], g);
    bit_clk(1'b1, g);
    ack = !g;
  endtask
endmodule
`default_nettype wire

// File: acd_checker.sv
`timescale 1ns/100ps
`default_nettype none
module acd_checker (
  input wire logic i_core_clk,
  input wire logic i_rstn,
  input wire logic i_scan_start,
  input wire logic i_scan_next,
  input wire logic [1:0] o_scan_mode,
  input wire logic [3:0] o_channel_code,
  input wire logic o_single_ended_select,
  input wire logic o_reference_pin_select_mid,
  input wire logic [3:0] o_mux_pos,
  input wire logic [3:0] o_mux_neg,
  input wire logic o_neg_is_gnd,
  input wire logic o_invert,
  input wire logic o_sel_valid,
  input wire logic o_scan_busy,
  input wire logic o_scan_last
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rstn);
  logic [8:0] f;
  logic [8:0] prev_r;
  logic [3:0] c;
  logic se, rf, idle;
  // decode is registered on the same edge as the fields; judge it only once they hold a clock
  assign c = o_channel_code;
  assign se = o_single_ended_select;
  assign rf = o_reference_pin_select_mid;
  assign f = {o_scan_busy, o_scan_mode, c, se, rf};
  assign idle = (f == prev_r) && !o_scan_busy && !prev_r[8];
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) prev_r <= 9'h002;
    else prev_r <= f;
  end
  chk_scan_reset: assert property ($rose(i_rstn) |-> o_scan_mode == 2'h0)
    else $error("scan mode not cleared by reset");
  chk_code_reset: assert property ($rose(i_rstn) |-> c == 4'h0)
    else $error("channel code not cleared by reset");
  chk_se_reset: assert property ($rose(i_rstn) |-> se)
    else $error("input type not single-ended after reset");
  chk_se_pick: assert property (idle && se && c <= 4'hb &&
    !(rf && c == 4'hb) |-> o_sel_valid && o_mux_pos == c && o_neg_is_gnd)
    else $error("single-ended selection wrong");
  chk_reserved_code: assert property (idle && c > 4'hb |-> !o_sel_valid)
    else $error("reserved code accepted");
  chk_diff_pair: assert property (idle && !se && c <= 4'hb &&
    !(rf && c[3:1] == 3'h5) |-> o_sel_valid && !o_neg_is_gnd &&
    o_mux_pos == c && o_mux_neg == (c ^ 4'h1))
    else $error("differential pair wrong");
  chk_ref_top_se: assert property (idle && se && rf && c == 4'hb |-> !o_sel_valid)
    else $error("top input not ignored in reference mode");
  chk_ref_top_pair: assert property (idle && !se && rf && c[3:1] == 3'h5
    |-> o_mux_pos == 4'ha && o_neg_is_gnd && o_invert == c[0])
    else $error("top pair not converted against ground");
  chk_diff_step: assert property (o_scan_busy && i_scan_next && !i_scan_start
    && !se && !rf && o_scan_mode == 2'h0 && !o_scan_last
    |-> ##2 o_mux_pos == $past(o_mux_pos, 2) + 4'h2)
    else $error("differential scan did not step by two");
endmodule
bind acd_config_decode acd_checker chk (.i_core_clk(i_core_clk),
  .i_rstn(i_rstn), .i_scan_start(i_scan_start), .i_scan_next(i_scan_next),
  .o_scan_mode(o_scan_mode), .o_channel_code(o_channel_code),
  .o_single_ended_select(o_single_ended_select),
  .o_reference_pin_select_mid(o_reference_pin_select_mid),
  .o_mux_pos(o_mux_pos), .o_mux_neg(o_mux_neg), .o_neg_is_gnd(o_neg_is_gnd),
  .o_invert(o_invert), .o_sel_valid(o_sel_valid), .o_scan_busy(o_scan_busy),
  .o_scan_last(o_scan_last));
`default_nettype wire

// File: acd_testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic i_core_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic i_scan_start = 1'b0;
  logic i_scan_next = 1'b0;
  wire sda_oe, sda_o, m_scl, m_sda, se, rf, gnd, inv, ok, busy, last;
  wire [1:0] mode;
  wire [3:0] code, pos, neg;
  int n_errors = 0;
  int n_tests = 0;
  // open-drain line with pull-up: low while either side pulls
  wire sda = m_sda & ~(sda_oe & ~sda_o);
  always #25 i_core_clk = ~i_core_clk;
  acd_config_decode uut (.i_core_clk(i_core_clk), .i_rstn(i_rstn),
    .i_scl(m_scl), .i_sda(sda), .i_scan_start(i_scan_start),
    .i_scan_next(i_scan_next), .o_sda_out(sda_o), .o_sda_oe(sda_oe),
    .o_scan_mode(mode), .o_channel_code(code), .o_single_ended_select(se),
    .o_reference_pin_select_mid(rf), .o_mux_pos(pos), .o_mux_neg(neg),
    .o_neg_is_gnd(gnd), .o_invert(inv), .o_sel_valid(ok),
    .o_scan_busy(busy), .o_scan_last(last));
  acd_bus_master mst (.o_scl(m_scl), .o_sda(m_sda), .i_sda(sda));
  //////////////////////////////////////////////////////////////////////////
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("errors %0d of %0d checks", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // one frame: address byte, then a data byte only if address acked
  task automatic wr(input logic [7:0] a, input logic [7:0] b, input logic ak);
    logic g;
    mst.start();
    mst.write_byte(a, g);
    cmp(g, ak);
    if (g) begin
      mst.write_byte(b, g);
      cmp(g, 1'b1);
    end
    mst.stop();
    repeat (8) @(negedge i_core_clk);
  endtask
  // every code, both input types, every scan mode
  task automatic t_tables();
    logic [3:0] n;
    for (int i = 0; i < 32; i++) begin
      n = i[3:0];
      wr(8'h54, {1'b0, n[1:0], n, i[4]}, 1'b1);
      cmp({mode, code, se}, {n[1:0], n, i[4]});
      if (n > 4'hb) cmp(ok, 1'b0);
      else cmp({ok, gnd, inv, 1'b0, pos, neg},
        {1'b1, i[4], 2'b0, n, i[4] ? 4'h0 : n ^ 4'h1});
    end
  endtask
  // refused frames, a cut byte, then reference mode via setup bytes
  task automatic t_refused();
    logic g;
    wr(8'h54, 8'h17, 1'b1);
    wr(8'h56, 8'h10, 1'b0);
    wr(8'h55, 8'h10, 1'b0);
    mst.start();
    mst.write_byte(8'h54, g);
    for (int i = 0; i < 4; i++) mst.bit_clk(1'b0, g);
    mst.stop();
    repeat (8) @(negedge i_core_clk);
    cmp({mode, code, se, rf}, 8'h2e);
    wr(8'h54, 8'hb6, 1'b1);
    cmp({mode, code, se, rf, ok}, 9'h05e);
    wr(8'h54, 8'h16, 1'b1);
    cmp({ok, gnd, inv, 1'b0, pos, neg}, 12'hea0);
    wr(8'h54, 8'h14, 1'b1);
    cmp({ok, gnd, inv, 1'b0, pos, neg}, 12'hca0);
    wr(8'h54, 8'hb4, 1'b1);
    cmp({mode, code, se, rf}, 8'h03);
    wr(8'h54, 8'h82, 1'b1);
    cmp({mode, code, se, rf}, 8'h02);
  endtask
  // start a scan, then step it, checking channel, busy and last each step
  task automatic scan(input logic [7:0] cfg, input logic [3:0] p0,
    input logic [3:0] st, input int n);
    wr(8'h54, cfg, 1'b1);
    i_scan_start = 1'b1;
    @(negedge i_core_clk) i_scan_start = 1'b0;
    for (int k = 0; k < n; k++) begin
      repeat (3) @(negedge i_core_clk);
      cmp({busy, last, pos}, {1'b1, k == n - 1, 4'(p0 + st * k)});
      i_scan_next = 1'b1;
      @(negedge i_core_clk) i_scan_next = 1'b0;
    end
    repeat (3) @(negedge i_core_clk);
    cmp(busy, 1'b0);
  endtask
  // reference-mode scan stops below the shared pin; then a mid-run reset
  task automatic t_ref_reset();
    wr(8'h54, 8'ha6, 1'b1);
    scan(8'h17, 4'h0, 4'h1, 11);
    wr(8'h54, 8'h6e, 1'b1);
    cmp({mode, code, se, rf}, 8'hdd);
    @(negedge i_core_clk) i_rstn = 1'b0;
    repeat (2) @(negedge i_core_clk);
    i_rstn = 1'b1;
    repeat (6) @(negedge i_core_clk);
    cmp({mode, code, se, rf}, 8'h02);
    cmp({ok, gnd, inv, 1'b0, pos, neg}, 12'hc00);
  endtask
  //////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (4) @(negedge i_core_clk);
    i_rstn = 1'b1;
    repeat (6) @(negedge i_core_clk);
    cmp({mode, code, se, rf}, 8'h02);
    cmp({ok, gnd, inv, 1'b0, pos, neg}, 12'hc00);
    t_tables();
    t_refused();
    scan(8'h07, 4'h0, 4'h1, 4);
    scan(8'h0e, 4'h0, 4'h2, 4);
    scan(8'h25, 4'h2, 4'h0, 8);
    scan(8'h51, 4'h6, 4'h1, 3);
    scan(8'h69, 4'h4, 4'h0, 1);
    t_ref_reset();
    print_verdict();
  end
  // hang guard, about five times the expected run
  initial begin
    #2000000;
    n_errors++;
    print_verdict();
  end
endmodule
`default_nettype wire
